/* fpm_map.svh */
// register offsets, field positions, reset values and timing counts
`ifndef FPM_MAP_SVH
`define FPM_MAP_SVH

`define FPM_ADDR_W 8
`define FPM_OFF_WAKE 8'h64
`define FPM_OFF_RX_LEVELS 8'h7c
`define FPM_OFF_TX_LEVELS 8'h80
`define FPM_OFF_PMT 8'h84

`define FPM_PMT_READY 0
`define FPM_PMT_WAKE_EN 1
`define FPM_PMT_POLARITY 2
`define FPM_PMT_PULSE 3
`define FPM_PMT_STYLE 6
`define FPM_PMT_ENERGY_DETECT_ENABLE 8
`define FPM_PMT_WAKE_ON_LAN_ENABLE 9
`define FPM_PMT_PHY_RESET_REQUEST 10
`define FPM_PMT_STATE_LO 12
`define FPM_PMT_STATE_HI 13

`define FPM_RX_STATUS_RST 8'h00
`define FPM_RX_PAYLOAD_RST 16'h0000
`define FPM_TX_STATUS_RST 8'h00
`define FPM_TX_FREE_RST 16'h1200

`define FPM_CLK_PERIOD_NS 40
`define FPM_PHY_RESET_REQUEST_NS 100000
`define FPM_PHY_RESET_REQUEST_CYCLES \
	((`FPM_PHY_RESET_REQUEST_NS + `FPM_CLK_PERIOD_NS - 1) / `FPM_CLK_PERIOD_NS)
`define FPM_PULSE_MS 50
`define FPM_READY_CYCLES 16
`define FPM_TIMER_W 26

`define FPM_RESP_OKAY 2'b00
`define FPM_RESP_SLVERR 2'b10

`endif

/* fpm_pkg.sv */
// types shared by the power management register bank
package fpm_pkg;

	typedef enum logic [1:0] {
		FULL_POWER_STATE = 2'b00,
		WAKE_FRAME_SLEEP_STATE = 2'b01,
		ENERGY_DETECT_SLEEP_STATE = 2'b10,
		RESERVED_STATE = 2'b11
	} fpm_power_state_t;

	typedef enum logic [1:0] {
		RDY_START = 2'b00,
		RDY_WAIT = 2'b01,
		RDY_UP = 2'b11,
		RDY_SLEEP = 2'b10
	} fpm_ready_state_t;

	typedef struct packed {
		logic rxStatusPush;
		logic rxStatusPop;
		logic rxFrameDone;
		logic [15:0] rxFrameLen;
		logic rxPayloadPop;
		logic txStatusPush;
		logic txStatusPop;
		logic txPayloadPush;
		logic txFrameDone;
		logic [15:0] txFrameLen;
	} fpm_fifo_evt_t;

	typedef struct packed {
		logic level;
		logic drive;
	} fpm_wake_pin_t;

endpackage

/* fpm_down_timer.sv */
// loadable down counter with busy level and expiry pulse
`timescale 1ns/1ps
module fpm_down_timer #(
	parameter int unsigned WIDTH = 26
) (
	input wire logic clk,
	input wire logic rstSync_b,
	input wire logic load,
	input wire logic [WIDTH-1:0] loadValue,
	output logic busy,
	output logic expire
);
	logic [WIDTH-1:0] cnt_q;
	logic [WIDTH-1:0] cnt_d;

	assign busy = (cnt_q != '0);
	assign expire = (cnt_q == WIDTH'(1));
	assign cnt_d = load ? loadValue : (busy ? cnt_q - WIDTH'(1) : cnt_q);

	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end
endmodule // fpm_down_timer

/* fpm_regs.sv */
// fifo level and power management register bank on axi4-lite
// How it works
// - rx status words used sit in bits 23-16, read only, reset zero.
// - rx payload bytes used sit in bits 15-0, read only, reset zero.
// - each received frame adds its length rounded up to whole dwords.
// - tx status words used sit in bits 23-16, read only, reset zero.
// - tx payload free bytes sit in bits 15-0, read only, reset 1200h.
// - power control register stays readable in every reduced power state.
// - power control writes are ignored until one read of that register, made once ready, after reset or wake.
// - power state field bits 13-12 selects full, wake frame or energy sleep.
// - any write to the wake register wakes a sleeping device.
// - writing one to bit 10 holds phy reset 100us, then self clears.
// - writes to the phy reset bit are ignored while it reads high.
// - enabled wake-on-lan event raises interrupt, and gated wake output.
// - enabled energy detect event raises interrupt, and gated wake output.
// - bit 6 picks open drain when clear, push pull when set.
// - open drain wake output ignores polarity and is active low.
// - bit 0 reads one once the device is stable and accessible.
// - bit 3 set pulses the wake output 50ms, clear holds it.
// - bit 1 gates only the external wake output, not the interrupt.
`timescale 1ns/1ps
`include "fpm_map.svh"
module fpm_regs #(
	parameter int unsigned PULSE_CYCLES =
		(`FPM_PULSE_MS * 1000000) / `FPM_CLK_PERIOD_NS
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [`FPM_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [`FPM_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire fpm_pkg::fpm_fifo_evt_t fifoEvt,
	input wire logic wolEvent,
	input wire logic energyEvent,
	output fpm_pkg::fpm_power_state_t powerState,
	output logic phyReset,
	output logic wakeInterrupt,
	output fpm_pkg::fpm_wake_pin_t wakePin
);
	// rounds a byte count up to a whole number of dwords
	function automatic logic [15:0] dwordRound(input logic [15:0] len);
		logic [16:0] sum;
		sum = {1'b0, len} + 17'h00003;
		dwordRound = {sum[15:2], 2'b00};
	endfunction

	logic rstMeta_b;
	logic rstSync_b;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta_b <= 1'b0;
			rstSync_b <= 1'b0;
		end else begin
			rstMeta_b <= 1'b1;
			rstSync_b <= rstMeta_b;
		end
	end

	// bus handshakes
	logic wrFire;
	logic rdFire;
	logic bvalid_q;
	logic rvalid_q;
	logic [1:0] bresp_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;

	// write taken only with address and data together, one in flight
	assign wrFire = awvalid && wvalid && !bvalid_q;
	assign awready = wrFire;
	assign wready = wrFire;
	assign rdFire = arvalid && !rvalid_q;
	assign arready = rdFire;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign rvalid = rvalid_q;
	assign rresp = rresp_q;
	assign rdata = rdata_q;

	wire wrWake = (awaddr == `FPM_OFF_WAKE);
	wire wrPmt = (awaddr == `FPM_OFF_PMT);
	wire wrRo = (awaddr == `FPM_OFF_RX_LEVELS) ||
		(awaddr == `FPM_OFF_TX_LEVELS);
	wire wrMapped = wrWake || wrPmt || wrRo;
	wire rdWake = (araddr == `FPM_OFF_WAKE);
	wire rdRx = (araddr == `FPM_OFF_RX_LEVELS);
	wire rdTx = (araddr == `FPM_OFF_TX_LEVELS);
	wire rdPmt = (araddr == `FPM_OFF_PMT);
	wire rdMapped = rdWake || rdRx || rdTx || rdPmt;

	// readiness sequencing
	fpm_pkg::fpm_ready_state_t rdy_q;
	fpm_pkg::fpm_ready_state_t rdy_d;
	fpm_pkg::fpm_power_state_t pstate_q;
	logic readSeen_q;
	logic readyLoad;
	logic readyBusy;
	logic readyDone;
	logic ready;
	logic sleeping;
	logic wakeWrite;
	logic sleepWrite;
	logic pmtWrite;

	assign ready = (rdy_q == fpm_pkg::RDY_UP);
	assign sleeping = (rdy_q == fpm_pkg::RDY_SLEEP);
	assign readyLoad = (rdy_q == fpm_pkg::RDY_START);
	// only the wake register is heard while asleep
	assign wakeWrite = wrFire && wrWake && sleeping;
	// nothing but a wake is taken before a read
	assign pmtWrite = wrFire && wrPmt && ready && readSeen_q;
	wire [1:0] stateField = wdata[`FPM_PMT_STATE_HI:`FPM_PMT_STATE_LO];
	// reserved code is dropped rather than trusted
	assign sleepWrite = pmtWrite && wstrb[1] &&
		(stateField == 2'b01 || stateField == 2'b10);

	always_comb begin
		rdy_d = rdy_q;
		case (rdy_q)
			fpm_pkg::RDY_START: rdy_d = fpm_pkg::RDY_WAIT;
			fpm_pkg::RDY_WAIT: begin
				if (readyDone)
					rdy_d = fpm_pkg::RDY_UP;
			end
			fpm_pkg::RDY_UP: begin
				if (sleepWrite)
					rdy_d = fpm_pkg::RDY_SLEEP;
			end
			fpm_pkg::RDY_SLEEP: begin
				if (wakeWrite)
					rdy_d = fpm_pkg::RDY_START;
			end
			default: rdy_d = fpm_pkg::RDY_START;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstSync_b) begin
		if (!rstSync_b)
			rdy_q <= fpm_pkg::RDY_START;
		else
			rdy_q <= rdy_d;
	end

	fpm_down_timer #(
		.WIDTH(`FPM_TIMER_W)
	) readyTimer (
		.clk(ref_clk),
		.rstSync_b(rstSync_b),
		.load(readyLoad),
		.loadValue(`FPM_TIMER_W'(`FPM_READY_CYCLES)),
		.busy(readyBusy),
		.expire(readyDone)
	);

	// read seen flag, cleared by reset and by each wake
	always_ff @(posedge ref_clk or negedge rstSync_b) begin
		if (!rstSync_b)
			readSeen_q <= 1'b0;
		else if (wakeWrite)
			readSeen_q <= 1'b0;
		else if (rdFire && rdPmt && ready)
			readSeen_q <= 1'b1;
	end

	// power state field self clears on wake
	always_ff @(posedge ref_clk or negedge rstSync_b) begin
		if (!rstSync_b)
			pstate_q <= fpm_pkg::FULL_POWER_STATE;
		else if (wakeWrite)
			pstate_q <= fpm_pkg::FULL_POWER_STATE;
		else if (sleepWrite)
			pstate_q <= fpm_pkg::fpm_power_state_t'(stateField);
	end
	assign powerState = pstate_q;

	// control bits
	logic wolEn_q;
	logic edEn_q;
	logic style_q;
	logic polarity_q;
	logic pulse_q;
	logic wakeEn_q;

	always_ff @(posedge ref_clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			wolEn_q <= 1'b0;
			edEn_q <= 1'b0;
			style_q <= 1'b0;
			polarity_q <= 1'b0;
			pulse_q <= 1'b0;
			wakeEn_q <= 1'b0;
		end else if (pmtWrite) begin
			if (wstrb[1]) begin
				wolEn_q <= wdata[`FPM_PMT_WAKE_ON_LAN_ENABLE];
				edEn_q <= wdata[`FPM_PMT_ENERGY_DETECT_ENABLE];
			end
			if (wstrb[0]) begin
				style_q <= wdata[`FPM_PMT_STYLE];
				polarity_q <= wdata[`FPM_PMT_POLARITY];
				pulse_q <= wdata[`FPM_PMT_PULSE];
				wakeEn_q <= wdata[`FPM_PMT_WAKE_EN];
			end
		end
	end

	// phy reset, held by its own timer
	logic phyLoad;
	logic phyBusy;

	// a set bit shields itself from further writes
	assign phyLoad = pmtWrite && wstrb[1] &&
		wdata[`FPM_PMT_PHY_RESET_REQUEST] && !phyBusy;
	assign phyReset = phyBusy;

	fpm_down_timer #(
		.WIDTH(`FPM_TIMER_W)
	) phyTimer (
		.clk(ref_clk),
		.rstSync_b(rstSync_b),
		.load(phyLoad),
		.loadValue(`FPM_TIMER_W'(`FPM_PHY_RESET_REQUEST_CYCLES)),
		.busy(phyBusy),
		.expire()
	);

	// wake events: latched while their enable stays set
	logic wolHit_q;
	logic edHit_q;
	logic newHit;
	logic pulseBusy;
	logic wakeActive;

	assign newHit = (wolEvent && wolEn_q && !wolHit_q) ||
		(energyEvent && edEn_q && !edHit_q);

	always_ff @(posedge ref_clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			wolHit_q <= 1'b0;
			edHit_q <= 1'b0;
		end else begin
			wolHit_q <= wolEn_q && (wolHit_q || wolEvent);
			edHit_q <= edEn_q && (edHit_q || energyEvent);
		end
	end

	// interrupt ignores the output enable
	assign wakeInterrupt = wolHit_q || edHit_q;

	fpm_down_timer #(
		.WIDTH(`FPM_TIMER_W)
	) pulseTimer (
		.clk(ref_clk),
		.rstSync_b(rstSync_b),
		.load(newHit && pulse_q),
		.loadValue(`FPM_TIMER_W'(PULSE_CYCLES)),
		.busy(pulseBusy),
		.expire()
	);

	assign wakeActive = wakeEn_q && (pulse_q ? pulseBusy :
		wakeInterrupt);

	// open drain pulls low only when active; push pull always drives
	assign wakePin.level = style_q ? (wakeActive == polarity_q) :
		1'b0;
	assign wakePin.drive = style_q ? 1'b1 : wakeActive;

	// fifo level counters
	logic [7:0] rxStatus_q;
	logic [15:0] rxPayload_q;
	logic [7:0] txStatus_q;
	logic [15:0] txFree_q;

	wire [7:0] rxStatusD = rxStatus_q + {7'h00, fifoEvt.rxStatusPush} -
		{7'h00, fifoEvt.rxStatusPop};
	wire [15:0] rxAdd = fifoEvt.rxFrameDone ?
		dwordRound(fifoEvt.rxFrameLen) : 16'h0000;
	wire [15:0] rxSub = fifoEvt.rxPayloadPop ? 16'h0004 : 16'h0000;
	wire [7:0] txStatusD = txStatus_q + {7'h00, fifoEvt.txStatusPush} -
		{7'h00, fifoEvt.txStatusPop};
	wire [15:0] txAdd = fifoEvt.txFrameDone ?
		dwordRound(fifoEvt.txFrameLen) : 16'h0000;
	// the count trusts the host not to overfill
	wire [15:0] txSub = fifoEvt.txPayloadPush ? 16'h0004 : 16'h0000;

	always_ff @(posedge ref_clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			rxStatus_q <= `FPM_RX_STATUS_RST;
			rxPayload_q <= `FPM_RX_PAYLOAD_RST;
			txStatus_q <= `FPM_TX_STATUS_RST;
			txFree_q <= `FPM_TX_FREE_RST;
		end else begin
			rxStatus_q <= rxStatusD;
			rxPayload_q <= rxPayload_q + rxAdd - rxSub;
			txStatus_q <= txStatusD;
			txFree_q <= txFree_q + txAdd - txSub;
		end
	end

	// read data assembly, reserved bits zero
	logic [31:0] pmtWord;
	wire [31:0] rxWord = {8'h00, rxStatus_q, rxPayload_q};
	wire [31:0] txWord = {8'h00, txStatus_q, txFree_q};

	always_comb begin
		pmtWord = 32'h00000000;
		pmtWord[`FPM_PMT_STATE_HI:`FPM_PMT_STATE_LO] = pstate_q;
		pmtWord[`FPM_PMT_PHY_RESET_REQUEST] = phyBusy;
		pmtWord[`FPM_PMT_WAKE_ON_LAN_ENABLE] = wolEn_q;
		pmtWord[`FPM_PMT_ENERGY_DETECT_ENABLE] = edEn_q;
		pmtWord[`FPM_PMT_STYLE] = style_q;
		pmtWord[`FPM_PMT_PULSE] = pulse_q;
		pmtWord[`FPM_PMT_POLARITY] = polarity_q;
		pmtWord[`FPM_PMT_WAKE_EN] = wakeEn_q;
		pmtWord[`FPM_PMT_READY] = ready;
	end

	// power control answers in every state
	wire [31:0] rdWord = rdPmt ? pmtWord :
		rdRx ? rxWord : rdTx ? txWord : 32'h00000000;

	always_ff @(posedge ref_clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			rvalid_q <= 1'b0;
			rresp_q <= `FPM_RESP_OKAY;
			rdata_q <= 32'h00000000;
		end else if (rdFire) begin
			rvalid_q <= 1'b1;
			rresp_q <= rdMapped ? `FPM_RESP_OKAY : `FPM_RESP_SLVERR;
			rdata_q <= rdWord;
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			bvalid_q <= 1'b0;
			bresp_q <= `FPM_RESP_OKAY;
		end else if (wrFire) begin
			bvalid_q <= 1'b1;
			// ignored writes to mapped registers still finish okay; unmapped ones get slverr
			bresp_q <= wrMapped ? `FPM_RESP_OKAY : `FPM_RESP_SLVERR;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end
endmodule // fpm_regs

/* fpm_host_model.sv */
// host side axi4-lite master driving the register bank
`timescale 1ns/1ps
module fpm_host_model (
	input wire logic ref_clk,
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	input wire logic wready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic bvalid,
	input wire logic [1:0] bresp,
	output logic bready,
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	logic t;
	initial begin
		{awvalid, wvalid, arvalid, bready, rready} <= 5'h03;
		{awaddr, araddr, wdata, wstrb} <= '0;
	end
	// released address and data lines show the inverse, never the last value; wstrb keeps 4'hf
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		output logic [1:0] b);
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(negedge ref_clk);
			t = awready && wready;
			@(posedge ref_clk);
		end while (!t);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		awaddr <= ~a;
		wdata <= ~v;
		do begin
			@(negedge ref_clk);
			t = bvalid;
			b = bresp;
			@(posedge ref_clk);
		end while (!t);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v,
		output logic [1:0] r);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge ref_clk);
			t = arready;
			@(posedge ref_clk);
		end while (!t);
		arvalid <= 1'b0;
		araddr <= ~a;
		do begin
			@(negedge ref_clk);
			t = rvalid;
			v = rdata;
			r = rresp;
			@(posedge ref_clk);
		end while (!t);
	endtask
endmodule // fpm_host_model

/* fpm_regs_sva.sv */
// port assertions for the register bank
`timescale 1ns/1ps
`include "fpm_map.svh"
module fpm_regs_sva (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [`FPM_ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [31:0] wdata,
	input wire logic wvalid,
	input wire logic bvalid,
	input wire logic [`FPM_ADDR_W-1:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic wolEvent,
	input wire logic energyEvent,
	input wire fpm_pkg::fpm_power_state_t powerState,
	input wire logic phyReset,
	input wire logic wakeInterrupt
);
	wire wrTake = awvalid && wvalid && awready;
	wire pmtWr = wrTake && awaddr == `FPM_OFF_PMT;
	wire wakeWr = wrTake && awaddr == `FPM_OFF_WAKE;
	wire asleep = powerState != fpm_pkg::FULL_POWER_STATE;
	wire mapped = araddr inside {`FPM_OFF_WAKE, `FPM_OFF_RX_LEVELS,
		`FPM_OFF_TX_LEVELS, `FPM_OFF_PMT};
	// counts high cycles so a short or stretched phy reset shows
	logic [11:0] phyCnt_q;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			phyCnt_q <= 12'h0;
		else
			phyCnt_q <= phyReset ? phyCnt_q + 12'h1 : 12'h0;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	chk_wr_answer:
		assert property (wrTake |=> bvalid)
		else $error("write not answered");
	chk_rd_answer:
		assert property (arvalid && arready |=> rvalid)
		else $error("read not answered");
	chk_rd_unmapped:
		assert property (arvalid && arready && !mapped |=>
			rresp == `FPM_RESP_SLVERR && rdata == 32'h0)
		else $error("unmapped read not refused");
	chk_phy_len:
		assert property ($fell(phyReset) |-> phyCnt_q == 12'h9c4)
		else $error("phy reset length wrong");
	chk_phy_cause:
		assert property ($rose(phyReset) |-> $past(pmtWr && wdata[10]))
		else $error("phy reset without write");
	chk_wake_cause:
		assert property ($rose(wakeInterrupt) |->
			$past(wolEvent || energyEvent))
		else $error("wake interrupt without event");
	chk_sleep_entry:
		assert property (asleep && !$past(asleep) |->
			$past(pmtWr, 1) || $past(pmtWr, 2))
		else $error("sleep without control write");
	chk_wake_exit:
		assert property (!asleep && $past(asleep) |->
			$past(wakeWr, 1) || $past(wakeWr, 2))
		else $error("wake without wake write");
	cov_phy: cover property ($rose(phyReset));
	cov_irq: cover property ($rose(wakeInterrupt));
	cov_sleep: cover property (asleep && !$past(asleep));
endmodule // fpm_regs_sva
bind fpm_regs fpm_regs_sva i_fpm_regs_sva (.ref_clk, .rst_b, .awaddr,
	.awvalid, .awready, .wdata, .wvalid, .bvalid, .araddr, .arvalid,
	.arready, .rdata, .rresp, .rvalid, .wolEvent, .energyEvent,
	.powerState, .phyReset, .wakeInterrupt);

/* fpm_regs_tb.sv */
// self-checking bench for the fifo level and power register bank
`timescale 1ns/1ps
`include "fpm_map.svh"
module fpm_regs_tb;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] awaddr, araddr;
	logic awvalid, awready, wready, wvalid, bvalid, bready, arvalid;
	logic arready, rvalid, rready, phyReset, wakeInterrupt;
	logic wolEvent = 1'b0;
	logic energyEvent = 1'b0;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	fpm_pkg::fpm_fifo_evt_t fifoEvt = '0;
	fpm_pkg::fpm_power_state_t powerState;
	fpm_pkg::fpm_wake_pin_t wakePin;
	int n_fail = 0;
	int tests_run = 0;
	int cyc = 0;
	always #20 ref_clk = ~ref_clk;
	// short pulse keeps the run brief
	fpm_regs #(.PULSE_CYCLES(20)) i_fpm_regs (.ref_clk, .rst_b, .awaddr,
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .fifoEvt, .wolEvent, .energyEvent, .powerState,
		.phyReset, .wakeInterrupt, .wakePin);
	fpm_host_model i_fpm_host_model (.ref_clk, .awaddr, .awvalid,
		.awready, .wready, .wdata, .wstrb, .wvalid, .bvalid,
		.bresp, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready);
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, e);
		tests_run++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		i_fpm_host_model.wr(a, v, r);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		i_fpm_host_model.rd(a, d, r);
		chk($sformatf("reg %h", a), d, e);
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (24) @(posedge ref_clk);
		wr(`FPM_OFF_PMT, 32'h200);
		rdc(`FPM_OFF_PMT, 32'h1);
		wr(`FPM_OFF_PMT, 32'hffff_cab0);
		rdc(`FPM_OFF_PMT, 32'h201);
		wr(`FPM_OFF_TX_LEVELS, 32'h0);
		chk("bresp", {30'h0, r}, 32'h0);
		rdc(`FPM_OFF_RX_LEVELS, 32'h0);
		rdc(`FPM_OFF_TX_LEVELS, 32'h1200);
		rdc(8'h10, 32'h0);
		chk("rresp", {30'h0, r}, 32'h2);
		wr(8'h10, 32'h0);
		chk("bresp", {30'h0, r}, 32'h2);
		$display("test regs done");
		@(posedge ref_clk);
		fifoEvt.rxFrameDone <= 1'b1;
		fifoEvt.rxFrameLen <= 16'h5;
		fifoEvt.rxStatusPush <= 1'b1;
		fifoEvt.txStatusPush <= 1'b1;
		fifoEvt.txPayloadPush <= 1'b1;
		@(posedge ref_clk);
		fifoEvt <= '0;
		rdc(`FPM_OFF_RX_LEVELS, 32'h1_0008);
		rdc(`FPM_OFF_TX_LEVELS, 32'h1_11fc);
		@(posedge ref_clk);
		fifoEvt.rxFrameDone <= 1'b1;
		fifoEvt.rxFrameLen <= 16'h8;
		fifoEvt.rxStatusPop <= 1'b1;
		fifoEvt.rxPayloadPop <= 1'b1;
		fifoEvt.txStatusPop <= 1'b1;
		fifoEvt.txFrameDone <= 1'b1;
		fifoEvt.txFrameLen <= 16'h3;
		@(posedge ref_clk);
		fifoEvt <= '0;
		rdc(`FPM_OFF_RX_LEVELS, 32'hc);
		rdc(`FPM_OFF_TX_LEVELS, 32'h1200);
		$display("test fifo done");
		wr(`FPM_OFF_PMT, 32'h206);
		@(posedge ref_clk);
		wolEvent <= 1'b1;
		@(posedge ref_clk);
		wolEvent <= 1'b0;
		repeat (3) @(negedge ref_clk);
		chk("irq", {31'h0, wakeInterrupt}, 32'h1);
		chk("pin", {30'h0, wakePin}, 32'h1);
		wr(`FPM_OFF_PMT, 32'h246);
		@(negedge ref_clk);
		chk("pin", {30'h0, wakePin}, 32'h3);
		wr(`FPM_OFF_PMT, 32'h244);
		@(negedge ref_clk);
		chk("pin", {30'h0, wakePin}, 32'h1);
		chk("irq", {31'h0, wakeInterrupt}, 32'h1);
		wr(`FPM_OFF_PMT, 32'h4e);
		@(negedge ref_clk);
		chk("irq", {31'h0, wakeInterrupt}, 32'h0);
		wr(`FPM_OFF_PMT, 32'h14e);
		@(posedge ref_clk);
		energyEvent <= 1'b1;
		@(posedge ref_clk);
		energyEvent <= 1'b0;
		repeat (5) @(negedge ref_clk);
		chk("irq", {31'h0, wakeInterrupt}, 32'h1);
		chk("pin", {30'h0, wakePin}, 32'h3);
		repeat (25) @(negedge ref_clk);
		chk("pin", {30'h0, wakePin}, 32'h1);
		$display("test wake done");
		wr(`FPM_OFF_PMT, 32'h400);
		@(negedge ref_clk);
		chk("phy", {31'h0, phyReset}, 32'h1);
		rdc(`FPM_OFF_PMT, 32'h401);
		// a second request must not stretch the hold
		wr(`FPM_OFF_PMT, 32'h400);
		@(negedge ref_clk);
		chk("phy", {31'h0, phyReset}, 32'h1);
		while (phyReset !== 1'b0)
			@(posedge ref_clk);
		rdc(`FPM_OFF_PMT, 32'h1);
		$display("test phy done");
		// code 11b is never programmed
		for (logic [1:0] st = 2'h1; st != 2'h3; st++) begin
			wr(`FPM_OFF_PMT, {18'h0, st, 12'h0});
			@(negedge ref_clk);
			chk("state", {30'h0, powerState}, {30'h0, st});
			i_fpm_host_model.rd(`FPM_OFF_PMT, d, r);
			chk("ready", {31'h0, d[0]}, 32'h0);
			wr(`FPM_OFF_WAKE, 32'h0);
			@(negedge ref_clk);
			chk("state", {30'h0, powerState}, 32'h0);
			repeat (24) @(posedge ref_clk);
			wr(`FPM_OFF_PMT, 32'h200);
			rdc(`FPM_OFF_PMT, 32'h1);
		end
		$display("test sleep done");
		report_and_stop();
	end
endmodule // fpm_regs_tb
